// ---- hdl/usb_power_frame_pkg.sv ----
// Package with offsets, fields and types of the USB power, frame and token block
// What this block does
// - Activity pending shows unsignalled bus activity
// - Guard bit blocks sleep during activity
// - Busy reads one unless idle and ready
// - Suspend gates USB clock, transceiver low power
// - Enable off holds outputs, releases pins
// - Frame high reloaded on each SOF while enabled
// - Frame high upper bits read zero
// - Power control unused bits read zero
package usb_power_frame_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] PWRC_OFFSET = 8'h00;
   localparam logic [7:0] FRMH_OFFSET = 8'h04;
   localparam logic [7:0] TOK_OFFSET = 8'h08;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int ACT_PEND_BIT = 7;
   localparam int GUARD_BIT = 4;
   localparam int BUSY_BIT = 3;
   localparam int SUSPEND_BIT = 1;
   localparam int ENABLE_BIT = 0;
   localparam int FRAME_HIGH_W = 3;
   localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int READY_TIME_NS = 200;
   localparam int READY_CYCLES = (READY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ****************************************
   // Token codes and types
   // ****************************************
   localparam logic [3:0] PID_SETUP = 4'hd;
   localparam logic [3:0] PID_IN = 4'h9;
   localparam logic [3:0] PID_OUT = 4'h1;
   typedef struct packed {
      logic [3:0] token_type;
      logic [3:0] token_endpoint;
   } token_t;
   typedef struct packed {
      logic sof_valid;
      logic [10:0] frame_number;
   } sof_t;
endpackage : usb_power_frame_pkg

// ---- hdl/usb_power_frame_token_ctrl.sv ----
// USB power control, frame number high and token registers behind APB
`timescale 1ns/1ns
module usb_power_frame_token_ctrl
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic bus_activity_i,
   input wire logic irq_raised_i,
   input wire logic notify_pending_i,
   input wire logic sleep_req_i,
   input wire usb_power_frame_pkg::sof_t sof_i,
   output logic sleep_block_o,
   output logic usb_clk_en_o,
   output logic xcvr_low_power_o,
   output logic module_on_o,
   output logic pins_owned_o,
   output logic analog_en_o,
   output usb_power_frame_pkg::token_t token_o,
   output logic token_write_o
);
   import usb_power_frame_pkg::*;

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [1:0] act_s1_q, act_s2_q;
   logic [1:0] act_s1_d, act_s2_d;

   // Two stages for pin level activity inputs
   always_comb
   begin
      act_s1_d = {notify_pending_i, bus_activity_i};
      act_s2_d = act_s1_q;
   end

   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         act_s1_q <= 2'h0;
         act_s2_q <= 2'h0;
      end
      else
      begin
         act_s1_q <= act_s1_d;
         act_s2_q <= act_s2_d;
      end
   end

   // ****************************************
   // Registers and state
   // ****************************************
   logic enable_q, enable_d;
   logic suspend_q, suspend_d;
   logic guard_q, guard_d;
   logic act_pend_q, act_pend_d;
   logic [FRAME_HIGH_W-1:0] frame_high_q, frame_high_d;
   token_t token_q, token_d;
   logic token_wr_q, token_wr_d;
   logic [2:0] ready_cnt_q, ready_cnt_d;
   logic [31:0] rdata_q, rdata_d;
   logic busy;
   logic wr_en, rd_en, hit;

   assign wr_en = psel_i && penable_i && pwrite_i;
   assign rd_en = psel_i && penable_i && !pwrite_i;
   assign hit = (paddr_i == PWRC_OFFSET) || (paddr_i == FRMH_OFFSET) || (paddr_i == TOK_OFFSET);

   assign busy = enable_q || (ready_cnt_q != 3'h0);

   // Next state of control, status and data registers
   always_comb
   begin
      enable_d = enable_q;
      suspend_d = suspend_q;
      guard_d = guard_q;
      frame_high_d = frame_high_q;
      token_d = token_q;
      token_wr_d = 1'b0;
      ready_cnt_d = ready_cnt_q;
      rdata_d = rdata_q;
      act_pend_d = act_pend_q;
      if (enable_q)
         ready_cnt_d = 3'(READY_CYCLES);
      else if (ready_cnt_q != 3'h0)
         ready_cnt_d = ready_cnt_q - 3'h1;
      if (irq_raised_i)
         act_pend_d = 1'b0;
      if (act_s2_q[0] && enable_q)
         act_pend_d = 1'b1;
      if (sof_i.sof_valid && enable_q)
         frame_high_d = sof_i.frame_number[10:8];
      if (wr_en)
      begin
         case (paddr_i)
            PWRC_OFFSET:
            begin
               enable_d = pwdata_i[ENABLE_BIT];
               suspend_d = pwdata_i[SUSPEND_BIT];
               guard_d = pwdata_i[GUARD_BIT];
            end
            TOK_OFFSET:
            begin
               token_d = pwdata_i[7:0];
               token_wr_d = 1'b1;
            end
            default:
               rdata_d = rdata_q;
         endcase
      end
      if (rd_en)
      begin
         case (paddr_i)
            PWRC_OFFSET: rdata_d = {24'h0, act_pend_q, 2'h0, guard_q, busy, 1'b0, suspend_q, enable_q};
            FRMH_OFFSET: rdata_d = {29'h0, frame_high_q};
            TOK_OFFSET: rdata_d = {24'h0, token_q};
            default: rdata_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!nrst_i)
      begin
         enable_q <= 1'b0;
         suspend_q <= 1'b0;
         guard_q <= 1'b0;
         act_pend_q <= 1'b0;
         frame_high_q <= 3'h0;
         token_q <= 8'h0;
         token_wr_q <= 1'b0;
         ready_cnt_q <= 3'h0;
         rdata_q <= RESET_VALUE;
      end
      else
      begin
         enable_q <= enable_d;
         suspend_q <= suspend_d;
         guard_q <= guard_d;
         act_pend_q <= act_pend_d;
         frame_high_q <= frame_high_d;
         token_q <= token_d;
         token_wr_q <= token_wr_d;
         ready_cnt_q <= ready_cnt_d;
         rdata_q <= rdata_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Read data valid in the access cycle itself; APB answers at once
   assign prdata_o = (rd_en && hit) ? rdata_d : 32'h0;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !hit;

   assign sleep_block_o = guard_q && sleep_req_i && (act_s2_q[0] || act_s2_q[1] || act_pend_q);
   assign usb_clk_en_o = enable_q && !suspend_q;
   assign xcvr_low_power_o = !enable_q || suspend_q;
   assign module_on_o = enable_q;
   assign pins_owned_o = enable_q;
   assign analog_en_o = enable_q;
   assign token_o = token_q;
   assign token_write_o = token_wr_q;
endmodule : usb_power_frame_token_ctrl

// ---- tb/usb_pft_props.sv ----
// Checker on the ports of the USB power, frame and token block
`timescale 1ns/1ns
module usb_pft_props
   import usb_power_frame_pkg::*;
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic sleep_req_i,
   input wire logic sleep_block_o,
   input wire logic usb_clk_en_o,
   input wire logic xcvr_low_power_o,
   input wire logic module_on_o,
   input wire token_t token_o,
   input wire logic token_write_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   // Read access phase
   wire rd = psel_i && penable_i && !pwrite_i;
   sequence s_tokw;
      psel_i && penable_i && pwrite_i && paddr_i == TOK_OFFSET;
   endsequence
   property p_clk; usb_clk_en_o == (module_on_o && !xcvr_low_power_o); endproperty
   property p_off; !module_on_o |-> xcvr_low_power_o && !usb_clk_en_o; endproperty
   property p_blk; sleep_block_o |-> sleep_req_i; endproperty
   property p_busy; rd && paddr_i == PWRC_OFFSET && prdata_o[ENABLE_BIT] |-> prdata_o[BUSY_BIT]; endproperty
   property p_pc; rd && paddr_i == PWRC_OFFSET |-> prdata_o[31:8] == 0 && prdata_o[6:5] == 0 && !prdata_o[2]; endproperty
   property p_fh; rd && paddr_i == FRMH_OFFSET |-> prdata_o[31:3] == 0; endproperty
   property p_rst; $rose(nrst_i) |-> !module_on_o && token_o == 0; endproperty
   property p_tok; s_tokw |=> token_write_o ##1 !token_write_o; endproperty
   a_clk: assert property (p_clk) else $error("clock gate wrong");
   a_off: assert property (p_off) else $error("off state wrong");
   a_blk: assert property (p_blk) else $error("sleep block wrong");
   a_busy: assert property (p_busy) else $error("busy low while on");
   a_pc: assert property (p_pc) else $error("power bits wrong");
   a_fh: assert property (p_fh) else $error("frame bits wrong");
   a_rst: assert property (p_rst) else $error("reset value wrong");
   a_tok: assert property (p_tok) else $error("token strobe wrong");
endmodule : usb_pft_props
bind usb_power_frame_token_ctrl usb_pft_props u_props (.*);

// ---- tb/usb_bus_model.sv ----
// USB bus side sending SOF tokens
`timescale 1ns/1ns
module usb_bus_model
(
   input wire logic mclk_i,
   input wire logic go_i,
   input wire logic [10:0] frame_i,
   output usb_power_frame_pkg::sof_t sof_o = '0
);
   // One-cycle SOF, frame field scrambled between tokens
   always @(posedge mclk_i)
   begin
      sof_o.sof_valid <= go_i;
      sof_o.frame_number <= go_i ? frame_i : ~sof_o.frame_number;
   end
endmodule : usb_bus_model

// ---- tb/usb_power_frame_token_ctrl_tb.sv ----
// Bench for the USB power, frame and token block
`timescale 1ns/1ns
module usb_power_frame_token_ctrl_tb;
   import usb_power_frame_pkg::*;
   logic mclk_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, go = 0, err;
   logic bus_activity_i = 0, irq_raised_i = 0, notify_pending_i = 0, sleep_req_i = 0;
   logic [7:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0, prdata_o, q;
   logic [10:0] frame = '0;
   logic pready_o, pslverr_o, sleep_block_o, usb_clk_en_o, xcvr_low_power_o;
   logic module_on_o, pins_owned_o, analog_en_o, token_write_o;
   logic [3:0] codes [3] = '{PID_SETUP, PID_IN, PID_OUT};
   sof_t sof_i;
   token_t token_o;
   int failures = 0, checks_done = 0, cyc = 0;
   usb_power_frame_token_ctrl uut (.*);
   usb_bus_model bus (.mclk_i(mclk_i), .go_i(go), .frame_i(frame), .sof_o(sof_i));
   always #25 mclk_i = ~mclk_i;
   task automatic chk(input string n, input logic [31:0] s, e);
      checks_done++;
      if (s !== e)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // APB transfer, then one idle cycle
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i) penable_i <= 1;
      do @(posedge mclk_i); while (pready_o !== 1'b1);
      q = prdata_o;
      err = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
      @(posedge mclk_i);
   endtask : xfer
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
      xfer(0, a, 0);
      chk(n, q, e);
   endtask : rd
   task automatic end_sim;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim
   // Cycle ceiling against a hang
   always @(posedge mclk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         failures++;
         end_sim;
      end
   end
   initial
   begin
      repeat (2) @(posedge mclk_i);
      nrst_i <= 1;
      @(posedge mclk_i);
      rd("pwrc", PWRC_OFFSET, 0);
      rd("tok", TOK_OFFSET, 0);
      chk("xcvr", xcvr_low_power_o, 1);
      xfer(0, 8'h0c, 0);
      chk("unmapped", {err, q[30:0]}, 32'h8000_0000);
      xfer(1, PWRC_OFFSET, '1);
      rd("pwrc", PWRC_OFFSET, 32'h1b);
      chk("susp", {usb_clk_en_o, xcvr_low_power_o}, 1);
      xfer(1, PWRC_OFFSET, 32'h11);
      chk("on", {usb_clk_en_o, xcvr_low_power_o, module_on_o, pins_owned_o, analog_en_o}, 5'h17);
      $display("test power done");
      sleep_req_i <= 1;
      bus_activity_i <= 1;
      repeat (4) @(posedge mclk_i);
      chk("block", sleep_block_o, 1);
      rd("pend", PWRC_OFFSET, 32'h99);
      bus_activity_i <= 0;
      notify_pending_i <= 1;
      repeat (3) @(posedge mclk_i);
      irq_raised_i <= 1;
      @(posedge mclk_i) irq_raised_i <= 0;
      chk("notify", sleep_block_o, 1);
      rd("clear", PWRC_OFFSET, 32'h19);
      xfer(1, PWRC_OFFSET, 1);
      chk("noguard", sleep_block_o, 0);
      $display("test sleep done");
      frame <= 11'h5a3;
      go <= 1;
      @(posedge mclk_i) go <= 0;
      @(posedge mclk_i);
      xfer(1, FRMH_OFFSET, '1);
      rd("frmh", FRMH_OFFSET, 5);
      foreach (codes[i])
      begin
         xfer(1, TOK_OFFSET, {codes[i], 4'(i + 1)});
         chk("tok", token_o, {codes[i], 4'(i + 1)});
      end
      xfer(1, PWRC_OFFSET, 0);
      rd("busy", PWRC_OFFSET, 32'h08);
      // No register access until busy clears
      repeat (READY_CYCLES) @(posedge mclk_i);
      rd("idle", PWRC_OFFSET, 0);
      chk("off", {module_on_o, pins_owned_o, analog_en_o, xcvr_low_power_o}, 1);
      $display("test token and off done");
      end_sim;
   end
endmodule : usb_power_frame_token_ctrl_tb
